// File: hw/pwmcc_pkg.sv
// Purpose: Shared constants and types of the eight-channel pulse generator
// Assumes: Byte-wide register port, registers indexed by address
// Notes:   Counter, period and duty registers sit in banks of eight
package pwmcc_pkg;

	localparam int CHAN_N = 8;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam int PRE_W  = 3;
	localparam int FREE_W = 7;
	localparam int SCL_W  = 10;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_ENABLE       = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_POLARITY     = 5'h01;
	localparam logic [ADDR_W-1:0] OFS_CLK_CHOICE   = 5'h02;
	localparam logic [ADDR_W-1:0] OFS_PRESCALE     = 5'h03;
	localparam logic [ADDR_W-1:0] OFS_CENTRE       = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_SCALE_A      = 5'h05;
	localparam logic [ADDR_W-1:0] OFS_SCALE_B      = 5'h06;
	localparam logic [ADDR_W-1:0] OFS_COUNTER_BASE = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_PERIOD_BASE  = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_DUTY_BASE    = 5'h18;

	// Prescale field positions
	localparam int PRE_A_LSB = 0;
	localparam int PRE_B_LSB = 4;

	// Reset values
	localparam logic [DATA_W-1:0] RST_BYTE   = 8'h00;
	localparam logic [DATA_W-1:0] RST_PERIOD = 8'hFF;
	localparam logic [DATA_W-1:0] RST_DUTY   = 8'hFF;

	typedef enum logic {
		PWMCC_UP   = 1'b0,
		PWMCC_DOWN = 1'b1
	} pwmcc_dir_t;

	typedef struct packed {
		logic              enable;
		logic              centre;
		logic              polarity;
		logic [DATA_W-1:0] period;
		logic [DATA_W-1:0] duty;
	} pwmcc_chan_cfg_t;

	typedef struct packed {
		logic [DATA_W-1:0] count;
		logic              out;
		logic              periodEnd;
	} pwmcc_chan_stat_t;

endpackage

// File: hw/pwmcc_prescale.sv
// Purpose: Divides the bus clock into the two prescaled tick streams
// Assumes: Ticks are one-cycle enables on clk_sys
// Notes:   Select n gives one tick every 2^n cycles
`timescale 1ns/1ps
module pwmcc_prescale (
	// Clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           srst,
	// Source selects
	input  wire logic [pwmcc_pkg::PRE_W-1:0]    selA,
	input  wire logic [pwmcc_pkg::PRE_W-1:0]    selB,
	// Tick outputs
	output logic                                tickA,
	output logic                                tickB
);
	import pwmcc_pkg::*;

	logic [FREE_W-1:0] freeReg;
	logic [FREE_W-1:0] maskA;
	logic [FREE_W-1:0] maskB;

	function automatic logic [FREE_W-1:0] makeMask(
		input logic [PRE_W-1:0] sel);
		logic [FREE_W:0] full;
		full = (8'h01 << sel) - 8'h01;
		return full[FREE_W-1:0];
	endfunction

	assign maskA = makeMask(selA);
	assign maskB = makeMask(selB);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			freeReg <= '0;
		end else begin
			freeReg <= freeReg + 7'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tickA <= 1'b0;
			tickB <= 1'b0;
		end else begin
			tickA <= ((freeReg & maskA) == maskA);
			tickB <= ((freeReg & maskB) == maskB);
		end
	end

endmodule // pwmcc_prescale

// File: hw/pwmcc_channel.sv
// Purpose: One channel counter with duty compare and output toggle
// Assumes: Period and duty arrive already double buffered
// Notes:   Period value zero counts nothing and ends every tick
`timescale 1ns/1ps
module pwmcc_channel (
	// Clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       srst,
	// Channel time base and control
	input  wire logic                       tick,
	input  wire logic                       counterClear,
	input  wire pwmcc_pkg::pwmcc_chan_cfg_t cfg,
	// Channel state
	output pwmcc_pkg::pwmcc_chan_stat_t     stat
);
	import pwmcc_pkg::*;

	logic [DATA_W-1:0] countReg;
	logic [DATA_W-1:0] countNext;
	pwmcc_dir_t        dirReg;
	pwmcc_dir_t        dirNext;
	logic              outReg;
	logic              periodEnd;
	logic              match;

	always_comb begin
		countNext = countReg;
		dirNext   = dirReg;
		periodEnd = 1'b0;
		if (tick) begin
			if (cfg.period == RST_BYTE) begin
				countNext = RST_BYTE;
				dirNext   = PWMCC_UP;
				periodEnd = 1'b1;
			end else if (!cfg.centre) begin
				// Left aligned: period ticks per cycle [R5]
				if (countReg >= cfg.period - 8'h01) begin
					countNext = RST_BYTE;
					periodEnd = 1'b1;
				end else begin
					countNext = countReg + 8'h01;
				end
			end else begin
				// Centre aligned: up then down, twice the period [R5]
				unique case (dirReg)
					PWMCC_UP: begin
						countNext = countReg + 8'h01;
						if (countReg + 8'h01 >= cfg.period) begin
							dirNext = PWMCC_DOWN;
						end
					end
					PWMCC_DOWN: begin
						countNext = countReg - 8'h01;
						if (countReg <= 8'h01) begin
							countNext = RST_BYTE;
							dirNext   = PWMCC_UP;
							periodEnd = 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Compare the count about to stand, so the edge lines up with it
	assign match = tick && (countNext == cfg.duty);

	always_ff @(posedge clk_sys) begin
		if (srst || !cfg.enable || counterClear) begin
			countReg <= RST_BYTE;
			dirReg   <= PWMCC_UP;
		end else begin
			countReg <= countNext;
			dirReg   <= dirNext;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			outReg <= 1'b0;
		end else if (!cfg.enable || counterClear) begin
			outReg <= cfg.polarity;
		end else if (periodEnd) begin
			outReg <= match ? ~cfg.polarity : cfg.polarity; // [R9]
		end else if (match) begin
			outReg <= ~outReg; // [R9]
		end
	end

	assign stat.count     = countReg;
	assign stat.out       = outReg;
	assign stat.periodEnd = cfg.enable && periodEnd;

endmodule // pwmcc_channel

// File: hw/pwmcc_top.sv
// Purpose: Eight-channel pulse generator with clock choice and buffering
// Assumes: Byte register port; all clocks are tick enables on clk_sys
// Notes:   Scaled clock S ticks once per 2*scale prescaled ticks
`timescale 1ns/1ps
// Function
// [R1] Channels 0,1,4,5 use prescaled clock one, or derived clock one.
// [R2] Channels 2,3,6,7 use prescaled clock two, or derived clock two.
// [R3] Clock choice bits writable anytime; switch may distort one pulse.
// [R4] Prescale select chooses both prescaler sources independently, anytime.
// [R5] Period is clock times value, doubled when centre aligned.
// [R6] Period read returns last written value, not active one.
// [R7] Disabled channel period write loads buffer and active together.
// [R8] Each channel has its own duty register, accessible anytime.
// [R9] Output toggles when active duty equals channel counter.
// [R10] Enabled duty change waits for period end, counter write, disable.
// [R11] Disabled channel duty write loads buffer and active together.
// [R12] Enabled period change uses the same transfer events as duty.
module pwmcc_top (
	// Clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           srst,
	// Register port
	input  wire logic [pwmcc_pkg::ADDR_W-1:0]   addr,
	input  wire logic [pwmcc_pkg::DATA_W-1:0]   wrData,
	input  wire logic                           wrStrobe,
	input  wire logic                           rdStrobe,
	output logic      [pwmcc_pkg::DATA_W-1:0]   rdData,
	// Channel outputs
	output logic      [pwmcc_pkg::CHAN_N-1:0]   pwmOut
);
	import pwmcc_pkg::*;

	// Control registers
	logic [DATA_W-1:0] enableReg;
	logic [DATA_W-1:0] enableDlyReg;
	logic [DATA_W-1:0] polarityReg;
	logic [DATA_W-1:0] channelClockChoiceReg;
	logic [DATA_W-1:0] prescalerSourceChoiceReg;
	logic [DATA_W-1:0] centreAlignOnReg;
	logic [DATA_W-1:0] scaleReg [2];

	// Double buffered period and duty
	logic [DATA_W-1:0] periodBufReg [CHAN_N];
	logic [DATA_W-1:0] periodActReg [CHAN_N];
	logic [DATA_W-1:0] dutyBufReg   [CHAN_N];
	logic [DATA_W-1:0] dutyActReg   [CHAN_N];

	// Decoded strobes
	logic                wrEnable;
	logic                wrPolarity;
	logic                wrClkChoice;
	logic                wrPrescale;
	logic                wrCentre;
	logic [1:0]          wrScale;
	logic [CHAN_N-1:0]   wrCounter;
	logic [CHAN_N-1:0]   wrPeriod;
	logic [CHAN_N-1:0]   wrDuty;
	logic [CHAN_N-1:0]   disableEdge;
	logic [CHAN_N-1:0]   loadAct;

	// Time base
	logic                tickA;
	logic                tickB;
	logic [1:0]          tickPre;
	logic                tickScaledReg [2];
	logic [1:0]          tickScaled;
	logic [SCL_W-1:0]    scaleCntReg [2];
	logic [CHAN_N-1:0]   chanTick;

	pwmcc_chan_cfg_t     chanCfg  [CHAN_N];
	pwmcc_chan_stat_t    chanStat [CHAN_N];
	logic [DATA_W-1:0]   rdNext;

	// Bank decode: base offset plus channel number
	function automatic logic bankHit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] base,
		input int                chan);
		logic [ADDR_W-1:0] target;
		target = base + ADDR_W'(chan);
		return (a == target);
	endfunction

	// Chooses the tick for a channel from its group and choice bit
	function automatic logic chooseTick(
		input int           chan,
		input logic         choice,
		input logic [1:0]   pre,
		input logic [1:0]   scaled);
		logic grp;
		grp = (chan % 4) >= 2;
		return choice ? scaled[grp] : pre[grp];
	endfunction

	assign wrEnable    = wrStrobe && (addr == OFS_ENABLE);
	assign wrPolarity  = wrStrobe && (addr == OFS_POLARITY);
	assign wrClkChoice = wrStrobe && (addr == OFS_CLK_CHOICE);
	assign wrPrescale  = wrStrobe && (addr == OFS_PRESCALE);
	assign wrCentre    = wrStrobe && (addr == OFS_CENTRE);
	assign wrScale[0]  = wrStrobe && (addr == OFS_SCALE_A);
	assign wrScale[1]  = wrStrobe && (addr == OFS_SCALE_B);

	// Simple control registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			enableReg    <= RST_BYTE;
			enableDlyReg <= RST_BYTE;
		end else begin
			enableDlyReg <= enableReg;
			if (wrEnable) begin
				enableReg <= wrData;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			polarityReg <= RST_BYTE;
		end else if (wrPolarity) begin
			polarityReg <= wrData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			channelClockChoiceReg <= RST_BYTE;
		end else if (wrClkChoice) begin
			channelClockChoiceReg <= wrData; // [R3]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prescalerSourceChoiceReg <= RST_BYTE;
		end else if (wrPrescale) begin
			prescalerSourceChoiceReg <= wrData; // [R4]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			centreAlignOnReg <= RST_BYTE;
		end else if (wrCentre) begin
			centreAlignOnReg <= wrData;
		end
	end

	// Prescaled clocks, each with its own source select
	pwmcc_prescale u_prescale (
		.clk_sys (clk_sys),
		.srst    (srst),
		.selA    (prescalerSourceChoiceReg[PRE_A_LSB +: PRE_W]), // [R4]
		.selB    (prescalerSourceChoiceReg[PRE_B_LSB +: PRE_W]), // [R4]
		.tickA   (tickA),
		.tickB   (tickB)
	);

	assign tickPre = {tickB, tickA};
	assign tickScaled = {tickScaledReg[1], tickScaledReg[0]};

	// Scaled clocks; scale value zero divides by 512
	genvar s;
	generate
		for (s = 0; s < 2; s++) begin : g_scale
			logic [SCL_W-1:0] limit;
			assign limit = (scaleReg[s] == RST_BYTE)
				? 10'h1FF
				: SCL_W'({1'b0, scaleReg[s], 1'b0} - 10'h001);

			always_ff @(posedge clk_sys) begin
				if (srst) begin
					scaleReg[s] <= RST_BYTE;
				end else if (wrScale[s]) begin
					scaleReg[s] <= wrData;
				end
			end

			// Rewriting the scale restarts the division
			always_ff @(posedge clk_sys) begin
				if (srst || wrScale[s]) begin
					scaleCntReg[s]   <= '0;
					tickScaledReg[s] <= 1'b0;
				end else if (tickPre[s]) begin
					if (scaleCntReg[s] >= limit) begin
						scaleCntReg[s]   <= '0;
						tickScaledReg[s] <= 1'b1;
					end else begin
						scaleCntReg[s]   <= scaleCntReg[s] + 10'h001;
						tickScaledReg[s] <= 1'b0;
					end
				end else begin
					tickScaledReg[s] <= 1'b0;
				end
			end
		end
	endgenerate

	// Per channel buffering and counters
	genvar c;
	generate
		for (c = 0; c < CHAN_N; c++) begin : g_chan
			assign wrCounter[c] = wrStrobe
				&& bankHit(addr, OFS_COUNTER_BASE, c);
			assign wrPeriod[c]  = wrStrobe
				&& bankHit(addr, OFS_PERIOD_BASE, c);
			assign wrDuty[c]    = wrStrobe
				&& bankHit(addr, OFS_DUTY_BASE, c);
			assign disableEdge[c] = enableDlyReg[c] && !enableReg[c];

			// Transfer events for an enabled channel [R10] [R12]
			assign loadAct[c] = (enableReg[c]
				&& (chanStat[c].periodEnd || wrCounter[c]))
				|| disableEdge[c];

			// Channel clock choice by group [R1] [R2]
			assign chanTick[c] = chooseTick(c,
				channelClockChoiceReg[c], tickPre, tickScaled);

			always_ff @(posedge clk_sys) begin
				if (srst) begin
					periodBufReg[c] <= RST_PERIOD;
				end else if (wrPeriod[c]) begin
					periodBufReg[c] <= wrData; // [R6]
				end
			end

			always_ff @(posedge clk_sys) begin
				if (srst) begin
					periodActReg[c] <= RST_PERIOD;
				end else if (wrPeriod[c]
					&& (!enableReg[c] || loadAct[c])) begin
					periodActReg[c] <= wrData; // [R7]
				end else if (loadAct[c]) begin
					periodActReg[c] <= periodBufReg[c]; // [R12]
				end
			end

			always_ff @(posedge clk_sys) begin
				if (srst) begin
					dutyBufReg[c] <= RST_DUTY;
				end else if (wrDuty[c]) begin
					dutyBufReg[c] <= wrData; // [R8]
				end
			end

			always_ff @(posedge clk_sys) begin
				if (srst) begin
					dutyActReg[c] <= RST_DUTY;
				end else if (wrDuty[c]
					&& (!enableReg[c] || loadAct[c])) begin
					dutyActReg[c] <= wrData; // [R11]
				end else if (loadAct[c]) begin
					dutyActReg[c] <= dutyBufReg[c]; // [R10]
				end
			end

			assign chanCfg[c].enable   = enableReg[c];
			assign chanCfg[c].centre   = centreAlignOnReg[c]; // [R5]
			assign chanCfg[c].polarity = polarityReg[c];
			assign chanCfg[c].period   = periodActReg[c];
			assign chanCfg[c].duty     = dutyActReg[c]; // [R9]

			pwmcc_channel u_channel (
				.clk_sys      (clk_sys),
				.srst         (srst),
				.tick         (chanTick[c]),
				.counterClear (wrCounter[c]),
				.cfg          (chanCfg[c]),
				.stat         (chanStat[c])
			);

			assign pwmOut[c] = chanStat[c].out;
		end
	endgenerate

	// Read selection; unmapped offsets read as zero
	always_comb begin
		rdNext = RST_BYTE;
		unique case (addr)
			OFS_ENABLE:     rdNext = enableReg;
			OFS_POLARITY:   rdNext = polarityReg;
			OFS_CLK_CHOICE: rdNext = channelClockChoiceReg;
			OFS_PRESCALE:   rdNext = prescalerSourceChoiceReg;
			OFS_CENTRE:     rdNext = centreAlignOnReg;
			OFS_SCALE_A:    rdNext = scaleReg[0];
			OFS_SCALE_B:    rdNext = scaleReg[1];
			default: begin
				for (int i = 0; i < CHAN_N; i++) begin
					if (bankHit(addr, OFS_COUNTER_BASE, i)) begin
						rdNext = chanStat[i].count;
					end
					if (bankHit(addr, OFS_PERIOD_BASE, i)) begin
						rdNext = periodBufReg[i]; // [R6]
					end
					if (bankHit(addr, OFS_DUTY_BASE, i)) begin
						rdNext = dutyBufReg[i]; // [R8]
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdData <= RST_BYTE;
		end else if (rdStrobe) begin
			rdData <= rdNext;
		end
	end

endmodule // pwmcc_top

// File: sim/pwmcc_top_monitor.sv
// Purpose: Port-level checks of the eight-channel pulse generator
// Assumes: Shadow copies mirror period, duty, clock choice, prescale, enable and polarity writes
// Notes:   Bound to pwmcc_top below
`timescale 1ns/1ps
module pwmcc_top_monitor (
	// Clock and reset
	input wire logic                         clk_sys,
	input wire logic                         srst,
	// Register port
	input wire logic [pwmcc_pkg::ADDR_W-1:0] addr,
	input wire logic [pwmcc_pkg::DATA_W-1:0] wrData,
	input wire logic                         wrStrobe,
	input wire logic                         rdStrobe,
	input wire logic [pwmcc_pkg::DATA_W-1:0] rdData,
	// Channel outputs
	input wire logic [pwmcc_pkg::CHAN_N-1:0] pwmOut
);
	import pwmcc_pkg::*;
	logic [DATA_W-1:0] per_reg  [CHAN_N];
	logic [DATA_W-1:0] duty_reg [CHAN_N];
	logic [DATA_W-1:0] clk_reg, pre_reg, en_reg, pol_reg;
	logic [ADDR_W-1:0] addr_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	always_ff @(posedge clk_sys) begin
		addr_reg <= addr;
		if (srst) begin
			per_reg  <= '{default: RST_PERIOD};
			duty_reg <= '{default: RST_DUTY};
			clk_reg  <= RST_BYTE;
			pre_reg  <= RST_BYTE;
			en_reg   <= RST_BYTE;
			pol_reg  <= RST_BYTE;
		end else if (wrStrobe) begin
			if (addr[4:3] == 2'h2) per_reg[addr[2:0]] <= wrData;
			if (addr[4:3] == 2'h3) duty_reg[addr[2:0]] <= wrData;
			if (addr == OFS_CLK_CHOICE) clk_reg <= wrData;
			if (addr == OFS_PRESCALE) pre_reg <= wrData;
			if (addr == OFS_ENABLE) en_reg <= wrData;
			if (addr == OFS_POLARITY) pol_reg <= wrData;
		end
	end

	property p_rst_out;
		$fell(srst) |-> rdData == 8'h00 && pwmOut == 8'h00;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not cleared by reset");
	property p_rd_hold;
		!rdStrobe |=> $stable(rdData);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without a read");
	property p_per_read;
		rdStrobe && addr[4:3] == 2'h2 |=> rdData == per_reg[addr_reg[2:0]];
	endproperty
	a_per_read: assert property (p_per_read)
		else $error("period read not last written");
	property p_duty_read;
		rdStrobe && addr[4:3] == 2'h3 |=> rdData == duty_reg[addr_reg[2:0]];
	endproperty
	a_duty_read: assert property (p_duty_read)
		else $error("duty read not last written");
	property p_clk_read;
		rdStrobe && addr == OFS_CLK_CHOICE |=> rdData == clk_reg;
	endproperty
	a_clk_read: assert property (p_clk_read)
		else $error("clock choice read mismatch");
	property p_pre_read;
		rdStrobe && addr == OFS_PRESCALE |=>
			(rdData & 8'h77) == (pre_reg & 8'h77);
	endproperty
	a_pre_read: assert property (p_pre_read)
		else $error("prescale select read mismatch");
	property p_unmapped;
		rdStrobe && addr == 5'h07 |=> rdData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_idle;
		pol_reg == $past(pol_reg) && $past(pol_reg) == $past(pol_reg, 2) |->
			((pwmOut ^ pol_reg) &
			~(en_reg | $past(en_reg) | $past(en_reg, 2))) == 8'h00;
	endproperty
	a_idle: assert property (p_idle)
		else $error("disabled channel not at idle level");

	c_clk_read: cover property (rdStrobe && addr == OFS_CLK_CHOICE);
	c_run: cover property (en_reg != 8'h00 && $rose(pwmOut[0]));
	c_unmapped: cover property (rdStrobe && addr == 5'h07);
endmodule // pwmcc_top_monitor

bind pwmcc_top pwmcc_top_monitor u_pwmcc_top_monitor (
	.clk_sys(clk_sys), .srst(srst), .addr(addr), .wrData(wrData),
	.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
	.pwmOut(pwmOut));

// File: sim/test_pwm_channel_clock_period_duty.sv
// Purpose: Self-checking bench of the eight-channel pulse generator
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Periods measured in clk_sys cycles between output edges
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	miscompares++; $display("unexpected at %0t got %0h expected %0h", \
	$time, (g), (e)); end end
module test_pwm_channel_clock_period_duty;
	import pwmcc_pkg::*;
	logic              clk_sys, srst, wrStrobe, rdStrobe;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wrData, rdData, rv, v, lfsrState;
	logic [CHAN_N-1:0] pwmOut;
	int                miscompares, checks_done, cycles, p, d, hi, per;
	time               t0, t1;

	pwmcc_top u_pwmcc_top (.clk_sys(clk_sys), .srst(srst), .addr(addr),
		.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.rdData(rdData), .pwmOut(pwmOut));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			complete_run();
		end
	end

	function logic [7:0] rnd();
		lfsrState = {lfsrState[6:0], ^(lfsrState & 8'hB8)};
		return lfsrState;
	endfunction

	// Tick spacing: A every cycle, B every 2, SA 2*2 A, SB 2*3 B
	function automatic int iv(int n, bit c);
		if (n % 4 < 2) return c ? 4 : 1;
		return c ? 12 : 2;
	endfunction

	task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] x);
		addr <= a;
		wrData <= x;
		wrStrobe <= 1'b1;
		@(posedge clk_sys);
		wrStrobe <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] x);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk_sys);
		rdStrobe <= 1'b0;
		@(negedge clk_sys);
		x = rdData;
		@(posedge clk_sys);
	endtask

	task automatic waitLvl(int n, logic lvl);
		do @(negedge clk_sys); while (pwmOut[n] !== lvl);
	endtask

	task automatic meas(int n, output int h, output int q);
		waitLvl(n, 1'b0);
		waitLvl(n, 1'b1);
		t0 = $time;
		waitLvl(n, 1'b0);
		h = int'(($time - t0) / 50);
		waitLvl(n, 1'b1);
		q = int'(($time - t0) / 50);
		@(posedge clk_sys);
	endtask

	initial begin
		srst = 1'b1;
		addr = '0;
		wrData = '0;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		lfsrState = 8'h3E;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		// Reset values, then random write and read back
		for (int n = 0; n < CHAN_N; n++) begin
			rd(OFS_PERIOD_BASE | 5'(n), rv);
			`CHK(rv, RST_PERIOD)
			rd(OFS_DUTY_BASE | 5'(n), rv);
			`CHK(rv, RST_DUTY)
		end
		wr(OFS_ENABLE, 8'hFF);
		for (int n = 0; n < CHAN_N; n++) begin
			v = rnd();
			wr(OFS_PERIOD_BASE | 5'(n), v);
			rd(OFS_PERIOD_BASE | 5'(n), rv);
			`CHK(rv, v)
			v = rnd();
			wr(OFS_DUTY_BASE | 5'(n), v);
			rd(OFS_DUTY_BASE | 5'(n), rv);
			`CHK(rv, v)
			v = rnd();
			wr(OFS_CLK_CHOICE, v);
			rd(OFS_CLK_CHOICE, rv);
			`CHK(rv, v)
			v = rnd();
			wr(OFS_PRESCALE, v);
			rd(OFS_PRESCALE, rv);
			`CHK(rv & 8'h77, v & 8'h77)
		end
		wr(5'h07, rnd());
		rd(5'h07, rv);
		`CHK(rv, 8'h00)
		// Every channel on both of its clock choices, both alignments
		wr(OFS_PRESCALE, 8'h10);
		wr(OFS_SCALE_A, 8'h02);
		wr(OFS_SCALE_B, 8'h03);
		wr(OFS_POLARITY, 8'hFF);
		for (int n = 0; n < CHAN_N; n++) begin
			for (int k = 0; k < 4; k++) begin
				p = 3 + rnd() % 6;
				d = 1 + rnd() % (p - 1);
				wr(OFS_ENABLE, 8'h00);
				wr(OFS_CLK_CHOICE, {8{k[0]}});
				wr(OFS_CENTRE, {8{k[1]}});
				wr(OFS_PERIOD_BASE | 5'(n), 8'(p));
				wr(OFS_DUTY_BASE | 5'(n), 8'(d));
				wr(OFS_ENABLE, 8'h01 << n);
				meas(n, hi, per);
				`CHK(per, p * iv(n, k[0]) * (k[1] ? 2 : 1))
				if (!k[1]) `CHK(hi, d * iv(n, k[0]))
			end
		end
		// New values written early in a period wait for its end
		wr(OFS_ENABLE, 8'h00);
		wr(OFS_CLK_CHOICE, 8'h00);
		wr(OFS_CENTRE, 8'h00);
		wr(OFS_PERIOD_BASE, 8'h0A);
		wr(OFS_DUTY_BASE, 8'h06);
		wr(OFS_ENABLE, 8'h01);
		waitLvl(0, 1'b0);
		waitLvl(0, 1'b1);
		t0 = $time;
		@(posedge clk_sys);
		wr(OFS_PERIOD_BASE, 8'h06);
		wr(OFS_DUTY_BASE, 8'h02);
		waitLvl(0, 1'b0);
		t1 = $time;
		waitLvl(0, 1'b1);
		`CHK(int'((t1 - t0) / 50), 6)
		`CHK(int'(($time - t0) / 50), 10)
		meas(0, hi, per);
		`CHK(hi, 2)
		`CHK(per, 6)
		// Counter write clears the count and loads the buffered duty
		wr(OFS_DUTY_BASE, 8'h04);
		wr(OFS_COUNTER_BASE, 8'h00);
		repeat (2) @(negedge clk_sys);
		`CHK(pwmOut[0], 1'b1)
		repeat (2) @(negedge clk_sys);
		`CHK(pwmOut[0], 1'b0)
		@(posedge clk_sys);
		rd(OFS_COUNTER_BASE, rv);
		`CHK(rv, 8'h05)
		// Second reset in mid-run
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd(OFS_PERIOD_BASE, rv);
		`CHK(rv, RST_PERIOD)
		`CHK(pwmOut, 8'h00)
		complete_run();
	end
endmodule // test_pwm_channel_clock_period_duty
